// ==== logic/lvd_pkg.sv ====
package lvd_pkg;
   // Register byte addresses
   localparam logic [7:0] LVD_CTRL_ADDR = 8'h00;
   localparam logic [7:0] LVD_IRQ_STAT_ADDR = 8'h04;
   localparam logic [7:0] LVD_IRQ_CLR_ADDR = 8'h08;
   localparam logic [7:0] LVD_IRQ_EN_ADDR = 8'h0c;
   localparam logic [7:0] LVD_MASK_ADDR = 8'h10;
   // Control register fields
   localparam int LVD_FLAG_BIT = 0;
   localparam int LVD_MODE_BIT = 1;
   localparam int LVD_SRC_BIT = 2;
   localparam int LVD_EN_BIT = 7;
   localparam logic [7:0] LVD_CTRL_RST = 8'h00;
   localparam logic LVD_MASK_RST = 1'b1;
   // Status bits
   localparam int LVD_ST_DETECT = 0;
   localparam int LVD_ST_CHANGE = 1;
   localparam int LVD_ST_W = 2;
   // Stabilisation time, informative for software
   localparam int LVD_CLK_MHZ = 40;
   localparam int LVD_STAB_US = 10;
   localparam int LVD_STAB_CYC = LVD_STAB_US * LVD_CLK_MHZ;
endpackage

// ==== logic/lvd_detector.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Control bit 2 selects the external detect input as the compared source.
// - Control bit 7 enables detection when 1 and halts it when 0.
// - Control bit 0 is a read-only flag: input at or above the level.
// - Control bit 1 selects the action; 0 raises an interrupt on detection.
module lvd_detector
   import lvd_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Comparator outputs, asynchronous
   input wire logic ext_above_in,
   input wire logic supply_above_in,
   // Interrupt
   output logic irq_out
);
   logic [7:0] ctrl;
   logic mask;
   logic [LVD_ST_W-1:0] stat;
   logic [LVD_ST_W-1:0] irq_en;
   logic [2:0] ext_sync;
   logic [2:0] sup_sync;
   logic ext_lvl;
   logic sup_lvl;
   logic flag;
   logic flag_q;
   logic flag_valid;
   logic wr_acc;
   logic crossing;
   logic [LVD_ST_W-1:0] set_ev;
   logic [LVD_ST_W-1:0] clr_ev;

   // Gated by pready so a stalled access cannot write twice
   assign wr_acc = psel_in && penable_in && pwrite_in && pready_out;

   // Three-stage synchronisers; change accepted when stages 2 and 3 agree
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ext_sync <= 3'h0;
         sup_sync <= 3'h0;
         ext_lvl <= 1'b0;
         sup_lvl <= 1'b0;
      end else begin
         ext_sync <= {ext_sync[1:0], ext_above_in};
         sup_sync <= {sup_sync[1:0], supply_above_in};
         if (ext_sync[1] == ext_sync[2]) begin
            ext_lvl <= ext_sync[2];
         end
         if (sup_sync[1] == sup_sync[2]) begin
            sup_lvl <= sup_sync[2];
         end
      end
   end

   // Source mux, supply while the select bit is 0
   assign flag = ctrl[LVD_SRC_BIT] ? ext_lvl : sup_lvl;

   // Control register; bit 0 never stored, so writes to it are ignored
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl <= LVD_CTRL_RST;
      end else begin
         if (wr_acc && paddr_in == LVD_CTRL_ADDR) begin
            ctrl <= {pwdata_in[7:1], 1'b0};
         end else begin
            ctrl[LVD_FLAG_BIT] <= ctrl[LVD_EN_BIT] && flag;
         end
      end
   end

   // Interrupt mask, set at reset so enabling starts masked
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mask <= LVD_MASK_RST;
      end else if (wr_acc && paddr_in == LVD_MASK_ADDR) begin
         mask <= pwdata_in[0];
      end
   end

   // Edge history only meaningful one cycle after enable
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flag_q <= 1'b0;
         flag_valid <= 1'b0;
      end else begin
         flag_q <= flag;
         flag_valid <= ctrl[LVD_EN_BIT];
      end
   end

   assign crossing = ctrl[LVD_EN_BIT] && flag_valid
                     && (flag != flag_q);
   assign set_ev[LVD_ST_DETECT] = crossing
                                  && !ctrl[LVD_MODE_BIT];
   assign set_ev[LVD_ST_CHANGE] = crossing;
   assign clr_ev = (wr_acc && paddr_in == LVD_IRQ_CLR_ADDR) ?
                   pwdata_in[LVD_ST_W-1:0] : '0;

   // Sticky status; a set in the clearing cycle wins
   generate
      for (genvar i = 0; i < LVD_ST_W; i++) begin : g_stat
         always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               stat[i] <= 1'b0;
            end else if (set_ev[i]) begin
               stat[i] <= 1'b1;
            end else if (clr_ev[i]) begin
               stat[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_en <= '0;
      end else if (wr_acc && paddr_in == LVD_IRQ_EN_ADDR) begin
         irq_en <= pwdata_in[LVD_ST_W-1:0];
      end
   end

   // Request flag reaches the pin only while unmasked
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= !mask && |(stat & irq_en);
      end
   end

   // APB: zero wait states, error on unmapped address
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prdata_out <= 32'h0;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0;
         if (psel_in && !penable_in) begin
            case (paddr_in)
               LVD_CTRL_ADDR: prdata_out <= {24'h0, ctrl};
               LVD_IRQ_STAT_ADDR: prdata_out <= {30'h0, stat};
               LVD_IRQ_CLR_ADDR: prdata_out <= 32'h0;
               LVD_IRQ_EN_ADDR: prdata_out <= {30'h0, irq_en};
               LVD_MASK_ADDR: prdata_out <= {31'h0, mask};
               default: pslverr_out <= 1'b1;
            endcase
         end
      end
   end

   // Assertions
   property p_flag_off;
      @(posedge clk_in) disable iff (!arst_n_in)
      !ctrl[LVD_EN_BIT] && !(wr_acc && paddr_in == LVD_CTRL_ADDR)
         |=> !ctrl[LVD_FLAG_BIT];
   endproperty
   a_flag_off: assert property (p_flag_off)
      else $error("flag set while off");

   property p_flag_src;
      @(posedge clk_in) disable iff (!arst_n_in)
      ctrl[LVD_EN_BIT] && ctrl[LVD_SRC_BIT] && $stable(ctrl[7:1])
         && !wr_acc |=> ctrl[LVD_FLAG_BIT] == $past(ext_lvl);
   endproperty
   a_flag_src: assert property (p_flag_src)
      else $error("flag not ext");

   property p_stop;
      @(posedge clk_in) disable iff (!arst_n_in)
      wr_acc && paddr_in == LVD_CTRL_ADDR && pwdata_in[7:0] == 8'h00
         |=> ctrl == 8'h00;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop write failed");

   property p_detect;
      @(posedge clk_in) disable iff (!arst_n_in)
      crossing && !ctrl[LVD_MODE_BIT] |=> stat[LVD_ST_DETECT];
   endproperty
   a_detect: assert property (p_detect)
      else $error("missed detect");

   property p_no_irq_mode1;
      @(posedge clk_in) disable iff (!arst_n_in)
      !stat[LVD_ST_DETECT] && ctrl[LVD_MODE_BIT]
         |=> !stat[LVD_ST_DETECT];
   endproperty
   a_no_irq_mode1: assert property (p_no_irq_mode1)
      else $error("mode 1 irq");

   property p_mask;
      @(posedge clk_in) disable iff (!arst_n_in)
      mask |=> !irq_out;
   endproperty
   a_mask: assert property (p_mask)
      else $error("irq while masked");

   property p_clear;
      @(posedge clk_in) disable iff (!arst_n_in)
      clr_ev[0] && !set_ev[0] |=> !stat[0];
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear failed");

   property p_ro;
      @(posedge clk_in) disable iff (!arst_n_in)
      wr_acc && paddr_in == LVD_CTRL_ADDR |=> !ctrl[LVD_FLAG_BIT];
   endproperty
   a_ro: assert property (p_ro)
      else $error("flag writable");
endmodule

// ==== tb/test_lvd_detector.sv ====
`timescale 1ns/1ps
module test_lvd_detector;
   import lvd_pkg::*;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic ext_above_in = 1'b0;
   logic supply_above_in = 1'b0;
   logic [31:0] prdata_out;
   logic [31:0] rd;
   logic pready_out, pslverr_out, irq_out, er;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;

   always #12.5 clk_in = ~clk_in;

   lvd_detector i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out),
      .ext_above_in(ext_above_in), .supply_above_in(supply_above_in),
      .irq_out(irq_out));

   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Slave answer time is not assumed; bounded wait on pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_in);
      end
      if (n == 20) begin
         bad_count++;
         $display("[ERR] %0t no pready", $time);
      end
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic t_reset;
      rdchk(LVD_CTRL_ADDR, 32'h0);
      rdchk(LVD_MASK_ADDR, 32'h1);
      rdchk(LVD_IRQ_STAT_ADDR, 32'h0);
      rdchk(LVD_IRQ_EN_ADDR, 32'h0);
      apb(1'b1, 8'h20, 32'hff);
      chk(er, 32'h1);
      chk(irq_out, 32'h0);
   endtask

   task automatic t_source;
      ext_above_in <= 1'b1;
      apb(1'b1, LVD_CTRL_ADDR, 32'h84);
      wt(LVD_STAB_CYC);
      rdchk(LVD_CTRL_ADDR, 32'h85);
      apb(1'b1, LVD_CTRL_ADDR, 32'h80);
      wt(10);
      rdchk(LVD_CTRL_ADDR, 32'h80);
      apb(1'b1, LVD_CTRL_ADDR, 32'h81);
      rdchk(LVD_CTRL_ADDR, 32'h80);
      supply_above_in <= 1'b1;
      wt(10);
      rdchk(LVD_CTRL_ADDR, 32'h81);
      supply_above_in <= 1'b0;
      wt(10);
   endtask

   task automatic t_irq;
      apb(1'b1, LVD_MASK_ADDR, 32'h1);
      apb(1'b1, LVD_CTRL_ADDR, 32'h84);
      wt(LVD_STAB_CYC);
      rdchk(LVD_CTRL_ADDR, 32'h85);
      apb(1'b1, LVD_IRQ_CLR_ADDR, 32'h3);
      apb(1'b1, LVD_MASK_ADDR, 32'h0);
      apb(1'b1, LVD_IRQ_EN_ADDR, 32'h1);
      rdchk(LVD_IRQ_STAT_ADDR, 32'h0);
      chk(irq_out, 32'h0);
      ext_above_in <= 1'b0;
      wt(10);
      rdchk(LVD_IRQ_STAT_ADDR, 32'h3);
      chk(irq_out, 32'h1);
      apb(1'b1, LVD_MASK_ADDR, 32'h1);
      wt(2);
      chk(irq_out, 32'h0);
      apb(1'b1, LVD_MASK_ADDR, 32'h0);
      wt(2);
      chk(irq_out, 32'h1);
      apb(1'b1, LVD_IRQ_EN_ADDR, 32'h0);
      wt(2);
      chk(irq_out, 32'h0);
      apb(1'b1, LVD_IRQ_EN_ADDR, 32'h1);
      apb(1'b1, LVD_IRQ_CLR_ADDR, 32'h3);
      wt(2);
      chk(irq_out, 32'h0);
      rdchk(LVD_IRQ_STAT_ADDR, 32'h0);
      rdchk(LVD_IRQ_CLR_ADDR, 32'h0);
      // Action select 1: crossing sets the change status bit but no request
      apb(1'b1, LVD_CTRL_ADDR, 32'h86);
      wt(5);
      apb(1'b1, LVD_IRQ_CLR_ADDR, 32'h3);
      ext_above_in <= 1'b1;
      wt(10);
      rdchk(LVD_IRQ_STAT_ADDR, 32'h2);
      chk(irq_out, 32'h0);
   endtask

   task automatic t_stop;
      apb(1'b1, LVD_CTRL_ADDR, 32'h84);
      wt(LVD_STAB_CYC);
      apb(1'b1, LVD_IRQ_CLR_ADDR, 32'h3);
      apb(1'b1, LVD_CTRL_ADDR, 32'h04);
      ext_above_in <= 1'b0;
      wt(10);
      rdchk(LVD_CTRL_ADDR, 32'h04);
      rdchk(LVD_IRQ_STAT_ADDR, 32'h0);
      apb(1'b1, LVD_CTRL_ADDR, 32'h84);
      wt(LVD_STAB_CYC);
      apb(1'b1, LVD_IRQ_CLR_ADDR, 32'h3);
      apb(1'b1, LVD_CTRL_ADDR, 32'h00);
      ext_above_in <= 1'b1;
      wt(10);
      rdchk(LVD_CTRL_ADDR, 32'h0);
      rdchk(LVD_IRQ_STAT_ADDR, 32'h0);
   endtask

   // Whole run is near 1800 cycles
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         $display("[ERR] %0t timeout", $time);
         end_of_test();
      end
   end

   initial begin
      wt(5);
      arst_n_in <= 1'b1;
      t_reset();
      t_source();
      t_irq();
      t_stop();
      end_of_test();
   end
endmodule
